// *** verilog/csc_pkg.sv ***
// Package for the CAN status and host-interface configuration block
package csc_pkg;
  // Register byte addresses (index times four)
  localparam logic [7:0] CSC_IDX_STATUS   = 8'h01;
  localparam logic [7:0] CSC_IDX_HOSTCFG  = 8'h02;
  localparam logic [7:0] CSC_IDX_CONTROL  = 8'h00;
  localparam logic [9:0] CSC_ADDR_CONTROL = 10'h000;
  localparam logic [9:0] CSC_ADDR_STATUS  = 10'h004;
  localparam logic [9:0] CSC_ADDR_HOSTCFG = 10'h008;
  // Host-interface values in and after reset
  localparam logic [7:0] CSC_HOSTCFG_IN_RST  = 8'he1;
  localparam logic [7:0] CSC_HOSTCFG_AFT_RST = 8'h41;
  localparam logic [7:0] CSC_CONTROL_RST     = 8'h01;
  // Host-interface bit positions
  localparam int CSC_HB_RSTPEND = 7;
  localparam int CSC_HB_SCLKH   = 6;
  localparam int CSC_HB_MCLKH   = 5;
  localparam int CSC_HB_PWD     = 4;
  localparam int CSC_HB_SLEEP   = 3;
  localparam int CSC_HB_IRQSEL  = 2;
  localparam int CSC_HB_STRETCH = 1;
  localparam int CSC_HB_CLKOEN  = 0;
  // Control bit positions
  localparam int CSC_CB_EIE  = 3;
  localparam int CSC_CB_SIE  = 2;
  localparam int CSC_CB_IE   = 1;
  localparam int CSC_CB_INIT = 0;
  // Error counter limits and recovery counts
  localparam logic [8:0] CSC_TEC_BUSOFF   = 9'h100;
  localparam logic [8:0] CSC_EC_WARN      = 9'h060;
  localparam logic [3:0] CSC_RECESSIVE_RUN = 4'hb;
  localparam logic [7:0] CSC_RECOVERY_SEQS = 8'h80;
  localparam logic [7:0] CSC_IRQ_ID_STATUS = 8'h01;
  // Last error codes
  typedef enum logic [2:0] {
    CSC_LEC_NONE  = 3'b000,
    CSC_LEC_STUFF = 3'b001,
    CSC_LEC_FORM  = 3'b010,
    CSC_LEC_ACK   = 3'b011,
    CSC_LEC_BIT1  = 3'b100,
    CSC_LEC_BIT0  = 3'b101,
    CSC_LEC_CRC   = 3'b110,
    CSC_LEC_UNUSD = 3'b111
  } csc_lec_e;
  typedef enum logic [1:0] {
    CSC_PM_NORMAL = 2'b00,
    CSC_PM_SLEEP  = 2'b01,
    CSC_PM_DOWN   = 2'b10
  } csc_pm_e;
  // Protocol events from the CAN engine
  typedef struct packed {
    logic       rx_ok;
    logic       tx_ok;
    logic       err_valid;
    logic [2:0] err_code;
    logic       frame_start;
    logic       bus_activity;
    logic       bit_valid;
    logic       bit_recessive;
  } csc_evt_s;
endpackage : csc_pkg

// *** verilog/csc_status_cfg.sv ***
// CAN status register, control bits and host-interface configuration
//
// Function
// (R01) Transmit counter 256 sets bus-off, halts traffic
// (R02) Clearing init starts recovery, zeroes error counters
// (R03) Leave bus-off after 128 eleven-recessive sequences
// (R04) Warning at 96; interrupt with ERROR_IRQ_ENABLE, IE
// (R05) Wake zero in sleep; set on exit
// (R06) Status read clears wake flag and interrupt
// (R07) Receive flag set per good frame
// (R08) Transmit flag set per acknowledged send
// (R09) Last error code encoding zero to six
// (R10) Recovery recessive bit writes code five
// (R11) First error kept; cleared on success
// (R12) Status change makes interrupt identifier one
// (R13) Every success raises status change interrupt
// (R14) Host-interface reads E1 in reset, 41 after
// (R15) Reset pending refuses all but host-interface reads
// (R16) Host-interface reachable without clock or sleep
// (R17) System clock halve selects crystal divided two
// (R18) Memory clock halve divides system clock
// (R19) Power mode decoded from down and sleep
// (R20) Bus activity in sleep clears sleep
// (R21) Pin select moves interrupt, primary floats
// (R22) Stretch holds clock output until data ready
// (R23) Entering bus-off sets init itself
// (R24) Read-only bits ignore writes; flags store writes
// (R25) Clock output enable gates pin, on after reset
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module csc_status_cfg
  import csc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire csc_evt_s    evt,
  input  wire logic        doubled_clock_en,
  input  wire logic        clockout_src,
  output logic             sys_clk_en,
  output logic             mem_clk_en,
  output csc_pm_e          power_mode,
  output logic             bus_enable,
  output logic [8:0]       tx_err_count,
  output logic [7:0]       rx_err_count,
  output logic [7:0]       irq_id,
  output logic             irq_primary_o,
  output logic             irq_primary_oe,
  output logic             irq_alternate,
  output logic             clockout
);

  //////////////////////////////////////////////////////////////////////
  // Bus front end
  logic       aph_valid_r;
  logic       aph_write_r;
  logic [9:0] aph_addr_r;
  logic [7:0] control_r;
  logic [7:0] hostcfg_r;
  logic       bus_off_flag_r;
  logic       warn_r;
  logic       wake_flag_r;
  logic       rx_success_flag_r;
  logic       tx_success_flag_r;
  logic [2:0] last_error_code_r;
  logic       in_frame_err_r;
  logic       recovering_r;
  logic [3:0] rec_run_r;
  logic [7:0] rec_seq_r;
  logic       status_irq_r;
  logic       wake_irq_r;
  logic       busoff_irq_r;
  logic       warn_irq_r;
  logic       reset_done_r;
  logic [1:0] sclk_div_r;
  logic       mclk_div_r;
  logic       stretch_hold_r;
  logic [8:0] tec_r;
  logic [7:0] rec_r;
  logic [7:0] status_view;
  logic       wr_ctl;
  logic       wr_sts;
  logic       wr_cfg;
  logic       rd_sts;
  logic       take;
  logic       recov_bit_seen;
  assign take   = hsel && hready && htrans[1];
  assign wr_ctl = aph_valid_r && aph_write_r && aph_addr_r == CSC_ADDR_CONTROL
                  && reset_done_r; // R15
  assign wr_sts = aph_valid_r && aph_write_r && aph_addr_r == CSC_ADDR_STATUS
                  && reset_done_r; // R15
  assign wr_cfg = aph_valid_r && aph_write_r && aph_addr_r == CSC_ADDR_HOSTCFG
                  && reset_done_r; // R15
  assign rd_sts = take && !hwrite && haddr[9:0] == CSC_ADDR_STATUS && reset_done_r;
  // Zero wait states: the data phase always completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aph_valid_r <= 1'b0;
      aph_write_r <= 1'b0;
      aph_addr_r  <= 10'h000;
    end else begin
      aph_valid_r <= take;
      aph_write_r <= hwrite;
      aph_addr_r  <= haddr[9:0];
    end
  end
  // Read data registered at the address phase; other addresses read zero
  // Reads win over reset so the host can poll the pending flag in reset
  always_ff @(posedge sys_clk) begin
    if (take && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (haddr[9:0] == CSC_ADDR_HOSTCFG)
        hrdata[7:0] <= hostcfg_r; // R15 R16
      else if (reset_done_r && haddr[9:0] == CSC_ADDR_STATUS)
        hrdata[7:0] <= status_view;
      else if (reset_done_r && haddr[9:0] == CSC_ADDR_CONTROL)
        hrdata[7:0] <= control_r;
    end else if (rst) begin
      hrdata <= 32'h0000_0000;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Reset pending and host-interface register
  // One cycle after release the pending flag drops; host polls it
  always_ff @(posedge sys_clk) begin
    if (rst) reset_done_r <= 1'b0;
    else     reset_done_r <= 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hostcfg_r <= CSC_HOSTCFG_IN_RST; // R14 R25
    end else begin
      if (!reset_done_r)
        hostcfg_r <= CSC_HOSTCFG_AFT_RST; // R14
      else if (wr_cfg)
        hostcfg_r <= {1'b0, hwdata[6:0]}; // R24
      if (reset_done_r && power_mode == CSC_PM_SLEEP && evt.bus_activity
          && !(wr_cfg && hwdata[CSC_HB_SLEEP]))
        hostcfg_r[CSC_HB_SLEEP] <= 1'b0; // R20
    end
  end
  always_comb begin
    unique case ({hostcfg_r[CSC_HB_PWD], hostcfg_r[CSC_HB_SLEEP]}) // R19
      2'b00:   power_mode = CSC_PM_NORMAL;
      2'b01:   power_mode = CSC_PM_SLEEP;
      default: power_mode = CSC_PM_DOWN;
    endcase
  end
  //////////////////////////////////////////////////////////////////////
  // Clock enables
  // Doubled clock is always halved (crystal rate); halve bit keeps one in four
  always_ff @(posedge sys_clk) begin
    if (rst) sclk_div_r <= 2'b00;
    else if (doubled_clock_en) sclk_div_r <= sclk_div_r + 2'b01;
  end
  assign sys_clk_en = doubled_clock_en && (hostcfg_r[CSC_HB_SCLKH] ?
                      (sclk_div_r == 2'b11) : sclk_div_r[0]); // R17
  always_ff @(posedge sys_clk) begin
    if (rst) mclk_div_r <= 1'b0;
    else if (sys_clk_en) mclk_div_r <= ~mclk_div_r;
  end
  assign mem_clk_en = sys_clk_en && (!hostcfg_r[CSC_HB_MCLKH] || mclk_div_r); // R18
  // Stretch: held from address acceptance until read data stands
  always_ff @(posedge sys_clk) begin
    if (rst) stretch_hold_r <= 1'b0;
    else     stretch_hold_r <= take && hostcfg_r[CSC_HB_STRETCH]; // R22
  end
  assign clockout = clockout_src && hostcfg_r[CSC_HB_CLKOEN]
                    && !stretch_hold_r && !(take && hostcfg_r[CSC_HB_STRETCH]); // R22 R25
  //////////////////////////////////////////////////////////////////////
  // Control bits and error counters
  assign recov_bit_seen = recovering_r && evt.bit_valid && evt.bit_recessive;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_r <= CSC_CONTROL_RST;
    end else begin
      if (wr_ctl) control_r <= {4'h0, hwdata[3:0]};
      if (!bus_off_flag_r && tec_r >= CSC_TEC_BUSOFF)
        control_r[CSC_CB_INIT] <= 1'b1; // R23
    end
  end
  // Counters grow on errors; recovery start zeroes both
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tec_r <= 9'h000;
      rec_r <= 8'h00;
    end else if (bus_off_flag_r && wr_ctl && !hwdata[CSC_CB_INIT]) begin
      tec_r <= 9'h000; // R02
      rec_r <= 8'h00;  // R02
    end else if (evt.err_valid && bus_enable) begin
      if (evt.err_code >= CSC_LEC_ACK && tec_r < CSC_TEC_BUSOFF)
        tec_r <= tec_r + 9'h008;
      else if (evt.err_code < CSC_LEC_ACK && rec_r != 8'hff)
        rec_r <= rec_r + 8'h01;
    end
  end
  assign tx_err_count = tec_r;
  assign rx_err_count = rec_r;
  assign bus_enable = !bus_off_flag_r && !control_r[CSC_CB_INIT]; // R01 R23
  //////////////////////////////////////////////////////////////////////
  // Bus-off and recovery
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_off_flag_r <= 1'b0;
      recovering_r   <= 1'b0;
      rec_run_r      <= 4'h0;
      rec_seq_r      <= 8'h00;
    end else begin
      if (!bus_off_flag_r && tec_r >= CSC_TEC_BUSOFF)
        bus_off_flag_r <= 1'b1; // R01
      if (bus_off_flag_r && wr_ctl && !hwdata[CSC_CB_INIT]) begin
        recovering_r <= 1'b1; // R02
        rec_run_r    <= 4'h0;
        rec_seq_r    <= 8'h00;
      end else if (recovering_r && evt.bit_valid) begin
        if (!evt.bit_recessive) begin
          rec_run_r <= 4'h0;
        end else if (rec_run_r == CSC_RECESSIVE_RUN - 4'h1) begin
          rec_run_r <= 4'h0; // R03
          if (rec_seq_r == CSC_RECOVERY_SEQS - 8'h01) begin
            recovering_r   <= 1'b0; // R03
            bus_off_flag_r <= 1'b0;
          end
          rec_seq_r <= rec_seq_r + 8'h01;
        end else begin
          rec_run_r <= rec_run_r + 4'h1;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Status flags
  always_ff @(posedge sys_clk) begin
    if (rst) warn_r <= 1'b0;
    else     warn_r <= tec_r >= CSC_EC_WARN || {1'b0, rec_r} >= CSC_EC_WARN; // R04
  end
  // Hardware set wins over a host write clearing the same flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_success_flag_r <= 1'b0;
      tx_success_flag_r <= 1'b0;
    end else begin
      if (wr_sts) rx_success_flag_r <= hwdata[4]; // R24
      if (wr_sts) tx_success_flag_r <= hwdata[3]; // R24
      if (evt.rx_ok && bus_enable) rx_success_flag_r <= 1'b1; // R07
      if (evt.tx_ok && bus_enable) tx_success_flag_r <= 1'b1; // R08
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_error_code_r <= CSC_LEC_NONE;
      in_frame_err_r    <= 1'b0;
    end else begin
      if (wr_sts) last_error_code_r <= hwdata[2:0]; // R11 R24
      if (evt.frame_start) in_frame_err_r <= 1'b0;
      if (recov_bit_seen) begin
        last_error_code_r <= CSC_LEC_BIT0; // R10
      end else if (bus_enable && evt.err_valid && !in_frame_err_r) begin
        last_error_code_r <= evt.err_code; // R09 R11
        in_frame_err_r    <= 1'b1;
      end else if (bus_enable && (evt.rx_ok || evt.tx_ok)) begin
        last_error_code_r <= CSC_LEC_NONE; // R11
      end
    end
  end
  // Wake: cleared while sleeping or by status read, set on leaving
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_flag_r <= 1'b0;
    end else if (power_mode == CSC_PM_SLEEP && evt.bus_activity) begin
      wake_flag_r <= 1'b1; // R05
    end else if (wr_cfg && power_mode == CSC_PM_SLEEP && !hwdata[CSC_HB_SLEEP]
                 && !hwdata[CSC_HB_PWD]) begin
      wake_flag_r <= 1'b1; // R05
    end else if (wr_cfg && power_mode == CSC_PM_DOWN && !hwdata[CSC_HB_PWD]) begin
      wake_flag_r <= 1'b1; // R05
    end else if (power_mode == CSC_PM_SLEEP || rd_sts) begin
      wake_flag_r <= 1'b0; // R05 R06
    end
  end
  assign status_view = {bus_off_flag_r, warn_r, wake_flag_r, rx_success_flag_r,
                        tx_success_flag_r, last_error_code_r};
  //////////////////////////////////////////////////////////////////////
  // Interrupts
  logic status_evt;
  assign status_evt = bus_enable && (evt.rx_ok || evt.tx_ok || evt.err_valid); // R13
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_irq_r <= 1'b0;
      wake_irq_r   <= 1'b0;
    end else begin
      if (rd_sts) status_irq_r <= 1'b0; // R12
      if (rd_sts) wake_irq_r   <= 1'b0; // R06
      if (control_r[CSC_CB_SIE] && (status_evt || recov_bit_seen))
        status_irq_r <= 1'b1; // R12 R13
      if (control_r[CSC_CB_SIE] && power_mode != CSC_PM_NORMAL && evt.bus_activity)
        wake_irq_r <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busoff_irq_r <= 1'b0;
      warn_irq_r   <= 1'b0;
    end else begin
      if (rd_sts) busoff_irq_r <= 1'b0;
      if (rd_sts) warn_irq_r   <= 1'b0;
      if (control_r[CSC_CB_EIE] && !bus_off_flag_r && tec_r >= CSC_TEC_BUSOFF)
        busoff_irq_r <= 1'b1;
      if (control_r[CSC_CB_EIE] && !warn_r &&
          (tec_r >= CSC_EC_WARN || {1'b0, rec_r} >= CSC_EC_WARN))
        warn_irq_r <= 1'b1; // R04
    end
  end
  logic irq_any;
  assign irq_any = control_r[CSC_CB_IE] &&
                   (status_irq_r || wake_irq_r || busoff_irq_r || warn_irq_r); // R04
  assign irq_id  = (status_irq_r || wake_irq_r || busoff_irq_r || warn_irq_r) ?
                   CSC_IRQ_ID_STATUS : 8'h00; // R12
  // Primary pin is active-low interrupt, floats when moved away
  assign irq_primary_o  = !irq_any;
  assign irq_primary_oe = !hostcfg_r[CSC_HB_IRQSEL]; // R21
  assign irq_alternate  = hostcfg_r[CSC_HB_IRQSEL] && irq_any; // R21
  //////////////////////////////////////////////////////////////////////
  // Checks
  a_busoff_sets_init: assert property (@(posedge sys_clk) disable iff (rst)
    (!bus_off_flag_r && tec_r >= CSC_TEC_BUSOFF) |=> bus_off_flag_r && control_r[0])
    else $error("bus-off entry missed"); // R01
  a_recov_clears_cnt: assert property (@(posedge sys_clk) disable iff (rst)
    (bus_off_flag_r && wr_ctl && !hwdata[0]) |=> tec_r == 9'h000 && recovering_r)
    else $error("recovery start wrong"); // R02
  a_warn_level: assert property (@(posedge sys_clk) disable iff (rst)
    (tec_r >= CSC_EC_WARN) |=> warn_r)
    else $error("warning not set"); // R04
  a_stsread_clr_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_sts && power_mode == CSC_PM_NORMAL) |=> !wake_flag_r && !wake_irq_r)
    else $error("status read kept wake"); // R06
  a_rx_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (evt.rx_ok && bus_enable) |=> rx_success_flag_r)
    else $error("receive flag not set"); // R07
  a_recov_code5: assert property (@(posedge sys_clk) disable iff (rst)
    recov_bit_seen |=> last_error_code_r == CSC_LEC_BIT0)
    else $error("recovery code not five"); // R10
  a_sie_irq_id: assert property (@(posedge sys_clk) disable iff (rst)
    (control_r[2] && status_evt) |=> irq_id == CSC_IRQ_ID_STATUS)
    else $error("status irq id missing"); // R12
  a_cfg_after_rst: assert property (@(posedge sys_clk)
    $fell(rst) |=> hostcfg_r == CSC_HOSTCFG_AFT_RST)
    else $error("host-interface not 41 after reset"); // R14
  a_irq_pin_float: assert property (@(posedge sys_clk) disable iff (rst)
    hostcfg_r[2] |-> !irq_primary_oe)
    else $error("primary pin driven"); // R21
  a_stretch_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (take && hostcfg_r[CSC_HB_STRETCH]) |=> !clockout)
    else $error("clock output not held"); // R22

endmodule : csc_status_cfg

// *** bench/csc_host_model.sv ***
// Host model: AHB-Lite master making single word transfers
`timescale 1ns/1ps
module csc_host_model
  import csc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             rd_done,
  output logic      [31:0] rd_word
);
  initial begin
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0;
    rd_done = 1'b0;
    rd_word = 32'h0;
  end
  ////////////////////////////////////////
  // Released data bus shows the inverse, so stale data never looks valid
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic note, output logic [31:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    hwdata  <= ~hwdata;
    rd_word <= hrdata;
    rd_done <= note & ~wr;
    @(posedge sys_clk);
    rd_done <= 1'b0;
  endtask : xfer
  // Nothing else is touched until the pending flag drops
  task automatic wait_ready(output logic ok);
    logic [31:0] q;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      xfer(1'b0, {22'h0, CSC_ADDR_HOSTCFG}, 32'h0, 1'b0, q);
      ok = (q[7] === 1'b0);
    end
  endtask : wait_ready
endmodule : csc_host_model

// *** bench/tb_top.sv ***
// Self-checking testbench for the CAN status and host-interface block
`timescale 1ns/1ps
module tb_top
  import csc_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  csc_evt_s    evt = '0;
  logic        dbl_en = 1'b0;
  logic        clk_src = 1'b0;
  logic        sclk_en;
  logic        mclk_en;
  csc_pm_e     pmode;
  logic        bus_en;
  logic [8:0]  tec;
  logic [7:0]  rec;
  logic [7:0]  irq_id;
  logic        irq_o;
  logic        irq_oe;
  logic        irq_alt;
  logic        clkout;
  logic        rd_done;
  logic [31:0] rd_word;
  logic [31:0] seed = 32'hf07f017b;
  logic [15:0] expq[$];
  logic        ok;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          n_sclk = 0;
  int          n_mclk = 0;
  int          a0;
  int          b0;
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Upper data bits are random: the block must use the low byte only
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    host.xfer(1'b1, {22'h0, a}, {seed[31:8], d}, 1'b0, q);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] q;
    expq.push_back({m, e});
    host.xfer(1'b0, {22'h0, a}, 32'h0, 1'b1, q);
  endtask : rd
  task automatic pulse(input logic [9:0] v, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      evt <= csc_evt_s'(v);
      @(posedge sys_clk);
      evt <= '0;
    end
  endtask : pulse
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
  end
  always @(posedge sys_clk) begin
    seed    <= xs(seed);
    dbl_en  <= ~dbl_en;
    clk_src <= seed[3];
    n_sclk  <= n_sclk + int'(sclk_en);
    n_mclk  <= n_mclk + int'(mclk_en);
  end
  always @(posedge sys_clk) begin
    if (rd_done === 1'b1) begin
      if (expq.size() == 0) begin
        chk("unexpected read", 32'h1, 32'h0);
      end else begin
        chk("read byte", 32'(expq[0][7:0]), 32'(expq[0][15:8] & rd_word[7:0]));
        void'(expq.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
  ////////////////////////////////////////
  csc_host_model host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rd_done(rd_done), .rd_word(rd_word));
  csc_status_cfg DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .evt(evt), .doubled_clock_en(dbl_en),
    .clockout_src(clk_src), .sys_clk_en(sclk_en), .mem_clk_en(mclk_en), .power_mode(pmode),
    .bus_enable(bus_en), .tx_err_count(tec), .rx_err_count(rec), .irq_id(irq_id),
    .irq_primary_o(irq_o), .irq_primary_oe(irq_oe), .irq_alternate(irq_alt),
    .clockout(clkout));
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    rd(CSC_ADDR_HOSTCFG, 8'hff, 8'he1);
    wr(CSC_ADDR_HOSTCFG, 8'h00);
    host.wait_ready(ok);
    chk("ready seen", 32'h1, 32'(ok));
    rd(CSC_ADDR_HOSTCFG, 8'hff, 8'h41);
    rd(CSC_ADDR_CONTROL, 8'hff, 8'h01);
    rd(10'h040, 8'hff, 8'h00);
    #2;
    chk("bus_enable", 32'h0, 32'(bus_en));
    chk("clockout", 32'(clk_src), 32'(clkout));
    for (int i = 0; i < 4; i++) begin
      wr(CSC_ADDR_HOSTCFG, {1'b1, i[1:0], 5'h01});
      rd(CSC_ADDR_HOSTCFG, 8'hff, {1'b0, i[1:0], 5'h01});
      #1;
      a0 = n_sclk;
      b0 = n_mclk;
      repeat (128) @(posedge sys_clk);
      #1;
      chk("sys_clk_en count", 32'(i[1] ? 16 : 32), 32'(n_sclk - a0));
      chk("mem_clk_en count", 32'(i[1] ? 16 : 32) >> i[0], 32'(n_mclk - b0));
    end
    wr(CSC_ADDR_HOSTCFG, 8'h00);
    repeat (6) begin
      @(posedge sys_clk);
      #2;
      chk("clockout gated", 32'h0, 32'(clkout));
    end
    for (int j = 0; j < 4; j++) begin
      wr(CSC_ADDR_HOSTCFG, {3'b000, j[1:0], 3'b001});
      #2;
      chk("power_mode", 32'(j[1] ? CSC_PM_DOWN : (j[0] ? CSC_PM_SLEEP : CSC_PM_NORMAL)),
          32'(pmode));
    end
    wr(CSC_ADDR_HOSTCFG, 8'h09);
    rd(CSC_ADDR_STATUS, 8'h20, 8'h00);
    wr(CSC_ADDR_HOSTCFG, 8'h01);
    rd(CSC_ADDR_STATUS, 8'h20, 8'h20);
    rd(CSC_ADDR_STATUS, 8'h20, 8'h00);
    wr(CSC_ADDR_HOSTCFG, 8'h11);
    wr(CSC_ADDR_HOSTCFG, 8'h01);
    rd(CSC_ADDR_STATUS, 8'h20, 8'h20);
    wr(CSC_ADDR_HOSTCFG, 8'h09);
    pulse(10'h004, 1);
    #2;
    chk("power_mode", 32'(CSC_PM_NORMAL), 32'(pmode));
    rd(CSC_ADDR_HOSTCFG, 8'hff, 8'h01);
    rd(CSC_ADDR_STATUS, 8'h20, 8'h20);
    // Error interrupts only, so the warning alone moves the identifier
    wr(CSC_ADDR_CONTROL, 8'h0a);
    pulse(10'h090, 1);
    pulse(10'h0b0, 11);
    rd(CSC_ADDR_STATUS, 8'h40, 8'h00);
    #2;
    chk("irq_id", 32'h0, 32'(irq_id));
    pulse(10'h0b0, 1);
    // Warning interrupt follows the counter by one edge
    @(posedge sys_clk);
    #2;
    chk("irq_id", 32'h1, 32'(irq_id));
    chk("tx_err_count", 32'd96, 32'(tec));
    rd(CSC_ADDR_STATUS, 8'hc0, 8'h40);
    pulse(10'h0b0, 20);
    rd(CSC_ADDR_STATUS, 8'h80, 8'h80);
    rd(CSC_ADDR_CONTROL, 8'h01, 8'h01);
    #2;
    chk("bus_enable", 32'h0, 32'(bus_en));
    wr(CSC_ADDR_CONTROL, 8'h0a);
    #2;
    chk("tx_err_count", 32'h0, 32'(tec));
    chk("rx_err_count", 32'h0, 32'(rec));
    pulse(10'h003, 11);
    rd(CSC_ADDR_STATUS, 8'h87, 8'h85);
    pulse(10'h003, 1396);
    rd(CSC_ADDR_STATUS, 8'h80, 8'h80);
    pulse(10'h003, 1);
    rd(CSC_ADDR_STATUS, 8'h80, 8'h00);
    #2;
    chk("bus_enable", 32'h1, 32'(bus_en));
    for (int c = 1; c < 7; c++) begin
      pulse(10'h008, 1);
      pulse({3'b001, 3'(c), 4'h0}, 1);
      pulse({3'b001, 3'(c % 6 + 1), 4'h0}, 1);
      rd(CSC_ADDR_STATUS, 8'h07, 8'(c));
    end
    wr(CSC_ADDR_CONTROL, 8'h06);
    pulse(10'h200, 1);
    rd(CSC_ADDR_STATUS, 8'h17, 8'h10);
    wr(CSC_ADDR_STATUS, 8'he7);
    rd(CSC_ADDR_STATUS, 8'hff, 8'h07);
    #2;
    chk("irq_id", 32'h0, 32'(irq_id));
    pulse(10'h100, 1);
    #2;
    chk("irq_id", 32'h1, 32'(irq_id));
    chk("irq_primary_oe", 32'h1, 32'(irq_oe));
    chk("irq_primary_o", 32'h0, 32'(irq_o));
    chk("irq_alternate", 32'h0, 32'(irq_alt));
    rd(CSC_ADDR_STATUS, 8'h0f, 8'h08);
    #2;
    chk("irq_id", 32'h0, 32'(irq_id));
    pulse(10'h100, 1);
    wr(CSC_ADDR_HOSTCFG, 8'h05);
    #2;
    chk("irq_id", 32'h1, 32'(irq_id));
    chk("irq_primary_oe", 32'h0, 32'(irq_oe));
    chk("irq_alternate", 32'h1, 32'(irq_alt));
    wr(CSC_ADDR_HOSTCFG, 8'h03);
    rd(CSC_ADDR_HOSTCFG, 8'hff, 8'h03);
    // Let the read checker see the last result before the verdict
    repeat (2) @(posedge sys_clk);
    give_verdict();
  end
endmodule : tb_top
